// ==== rtl/pmwc_ctrl.v ====
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "pmwc_map.vh"

module pmwc_ctrl (
	// Clock and reset
	input wire clock_in,
	input wire rst_in,
	// Wishbone slave
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [3:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output wire wb_ack_out,
	// Wake sources (asynchronous)
	input wire rtc_irq_in,
	input wire reset_pin_n_in,
	input wire eth_wake_in,
	input wire can_wake_in,
	input wire phy_wake_pin_in,
	// Power and clock control
	output reg core_clock_en_out,
	output reg sys_clock_en_out,
	output reg regulator_on_out,
	output reg [3:0] vlevel_out,
	output reg pll_bypass_out,
	output reg [5:0] pll_msel_out,
	output reg pll_half_out,
	output reg async_access_block_out,
	output reg pins_hiz_out,
	output reg sdram_cke_hold_low_out,
	output reg boot_start_out,
	output reg logic_reset_out,
	output wire buffered_clock_out
);

	reg [2:0] mode;
	reg [2:0] next_mode;
	reg [14:0] regulator_control_reg;
	reg [8:0] pll_control_reg;
	reg [7:0] boot_cnt;
	reg pll_unlocked;
	reg ack;
	reg [4:0] sync1;
	reg [4:0] sync2;
	reg rtc_q;

	wire [4:0] async_raw;
	wire [4:0] sync_idle = `PMWC_SYNC_IDLE;
	wire rtc_s = sync2[0];
	wire rst_s = ~sync2[1];
	wire eth_s = sync2[2];
	wire can_s = sync2[3];
	wire phy_s = ~sync2[4];
	wire rtc_rise = rtc_s & ~rtc_q;

	assign async_raw = {phy_wake_pin_in, can_wake_in, eth_wake_in, reset_pin_n_in, rtc_irq_in};

	////////////////////////////////////////////////////////////////
	// Input synchronisers, two stages per pin; active-low pins rest high
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			always @(posedge clock_in) begin
				if (rst_in) begin
					sync1[gi] <= sync_idle[gi];
					sync2[gi] <= sync_idle[gi];
				end else begin
					sync1[gi] <= async_raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	// Deep-sleep exit uses the RTC edge, so a held level wakes only once
	always @(posedge clock_in) begin
		if (rst_in)
			rtc_q <= 1'b0;
		else
			rtc_q <= rtc_s;
	end

	////////////////////////////////////////////////////////////////
	// Wishbone
	wire wb_req = wb_cyc_in & wb_stb_in & ~ack;
	wire wb_wr = wb_req & wb_we_in;
	assign wb_ack_out = ack;

	always @(posedge clock_in) begin
		if (rst_in)
			ack <= 1'b0;
		else
			ack <= wb_req;
	end

	// Gate the hibernate wake conditions with their enable bits
	wire hib_wake_rst = rst_s & regulator_control_reg[`PMWC_VR_WAKE_RST];
	wire hib_wake_rtc = rtc_s & regulator_control_reg[`PMWC_VR_WAKE_RTC];
	wire hib_wake_eth = eth_s & regulator_control_reg[`PMWC_VR_WAKE_ETH];
	wire hib_wake_can = can_s & regulator_control_reg[`PMWC_VR_WAKE_CAN];
	wire hib_wake_phy = phy_s & regulator_control_reg[`PMWC_VR_WAKE_PHY];
	wire hib_wake = hib_wake_rst | hib_wake_rtc | hib_wake_eth | hib_wake_can | hib_wake_phy;

	wire vr_write = wb_wr & (wb_adr_in == `PMWC_ADDR_VR) & (mode != `PMWC_M_HIB);
	wire pll_write = wb_wr & (wb_adr_in == `PMWC_ADDR_PLL) & (mode != `PMWC_M_HIB);
	wire cmd_write = wb_wr & (wb_adr_in == `PMWC_ADDR_CMD) & wb_sel_in[0];
	wire regulator_switch_field_off = vr_write & wb_sel_in[0] &
		(wb_dat_in[`PMWC_VR_REGULATOR_SWITCH_FIELD_HI:`PMWC_VR_REGULATOR_SWITCH_FIELD_LO] == `PMWC_REGULATOR_SWITCH_FIELD_OFF);

	////////////////////////////////////////////////////////////////
	// Regulator control register, kept across hibernate
	always @(posedge clock_in) begin
		if (rst_in) begin
			regulator_control_reg <= `PMWC_VR_RESET;
		end else if (vr_write) begin
			if (wb_sel_in[0])
				regulator_control_reg[7:0] <= wb_dat_in[7:0];
			if (wb_sel_in[1])
				regulator_control_reg[14:8] <= wb_dat_in[14:8];
		end else if (mode == `PMWC_M_HIB && hib_wake) begin
			// Regulator back on at the lowest nonzero setting
			regulator_control_reg[`PMWC_VR_REGULATOR_SWITCH_FIELD_HI:`PMWC_VR_REGULATOR_SWITCH_FIELD_LO] <= `PMWC_REGULATOR_SWITCH_FIELD_WAKE;
		end
	end

	////////////////////////////////////////////////////////////////
	// PLL control: writes take effect only after the key word
	always @(posedge clock_in) begin
		if (rst_in || logic_reset_out) begin
			pll_control_reg <= `PMWC_PLL_RESET;
			pll_unlocked <= 1'b0;
		end else if (pll_write && (&wb_sel_in[1:0])) begin
			if (pll_unlocked) begin
				pll_control_reg <= wb_dat_in[8:0];
				pll_unlocked <= 1'b0;
			end else begin
				pll_unlocked <= (wb_dat_in[15:0] == `PMWC_PLL_KEY);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode sequencer
	always @* begin
		next_mode = mode;
		case (mode)
			`PMWC_M_FULL, `PMWC_M_ACTIVE: begin
				if (regulator_switch_field_off)
					next_mode = `PMWC_M_HIB;
				else if (cmd_write && wb_dat_in[`PMWC_CMD_DEEP])
					next_mode = `PMWC_M_DEEP;
				else if (cmd_write && wb_dat_in[`PMWC_CMD_ACTIVE])
					next_mode = `PMWC_M_ACTIVE;
				else if (cmd_write && wb_dat_in[`PMWC_CMD_FULL])
					next_mode = `PMWC_M_FULL;
			end
			`PMWC_M_DEEP: begin
				// Nothing else leaves deep sleep
				if (rst_s)
					next_mode = `PMWC_M_FULL;
				else if (rtc_rise)
					next_mode = `PMWC_M_ACTIVE;
			end
			`PMWC_M_HIB: begin
				if (hib_wake)
					next_mode = `PMWC_M_BOOT;
			end
			`PMWC_M_BOOT: begin
				if (boot_cnt == `PMWC_BOOT_CYCLES && !rst_s)
					next_mode = `PMWC_M_FULL;
			end
			default: next_mode = `PMWC_M_FULL;
		endcase
	end

	always @(posedge clock_in) begin
		if (rst_in) begin
			mode <= `PMWC_M_FULL;
			boot_cnt <= 8'h00;
		end else begin
			mode <= next_mode;
			if (mode == `PMWC_M_BOOT && boot_cnt != `PMWC_BOOT_CYCLES)
				boot_cnt <= boot_cnt + 8'h01;
			else if (mode != `PMWC_M_BOOT)
				boot_cnt <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Output next values, taken from the mode about to be entered
	reg next_core_clock_en;
	reg next_sys_clock_en;
	reg next_regulator_on;
	reg next_pll_bypass;
	reg next_async_block;
	reg next_pins_hiz;
	reg next_cke_hold;
	reg next_boot_start;
	reg next_logic_reset;
	reg [31:0] next_rdat;
	wire next_clocks_on = (next_mode == `PMWC_M_FULL) || (next_mode == `PMWC_M_ACTIVE);
	wire next_unpowered = (next_mode == `PMWC_M_HIB) || (next_mode == `PMWC_M_BOOT);

	always @* begin
		next_core_clock_en = next_clocks_on;
		next_sys_clock_en = next_clocks_on;
		next_regulator_on = (next_mode != `PMWC_M_HIB);
		next_pll_bypass = (next_mode == `PMWC_M_ACTIVE) | pll_control_reg[`PMWC_PLL_BYPASS];
		next_async_block = (next_mode == `PMWC_M_DEEP);
		next_pins_hiz = (next_mode == `PMWC_M_HIB);
		next_cke_hold = regulator_control_reg[`PMWC_VR_CKE_LOW] & next_unpowered;
		next_boot_start = (mode == `PMWC_M_BOOT) && (next_mode == `PMWC_M_FULL);
		next_logic_reset = next_unpowered;
		next_rdat = wb_dat_out;
		if (wb_req && !wb_we_in) begin
			case (wb_adr_in)
				`PMWC_ADDR_VR: next_rdat = {17'h00000, regulator_control_reg};
				`PMWC_ADDR_PLL: next_rdat = {22'h000000, pll_unlocked, pll_control_reg};
				`PMWC_ADDR_MODE: next_rdat = {29'h00000000, mode};
				default: next_rdat = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Output registers
	always @(posedge clock_in) begin
		if (rst_in) begin
			core_clock_en_out <= 1'b1;
			sys_clock_en_out <= 1'b1;
			regulator_on_out <= 1'b1;
			vlevel_out <= 4'h0;
			pll_bypass_out <= 1'b0;
			pll_msel_out <= `PMWC_MSEL_DEFAULT;
			pll_half_out <= 1'b0;
			async_access_block_out <= 1'b0;
			pins_hiz_out <= 1'b0;
			sdram_cke_hold_low_out <= 1'b0;
			boot_start_out <= 1'b0;
			logic_reset_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			core_clock_en_out <= next_core_clock_en;
			sys_clock_en_out <= next_sys_clock_en;
			regulator_on_out <= next_regulator_on;
			vlevel_out <= regulator_control_reg[`PMWC_VR_VLEV_HI:`PMWC_VR_VLEV_LO];
			pll_bypass_out <= next_pll_bypass;
			pll_msel_out <= pll_control_reg[`PMWC_PLL_MSEL_HI:`PMWC_PLL_MSEL_LO];
			pll_half_out <= pll_control_reg[`PMWC_PLL_DF];
			async_access_block_out <= next_async_block;
			pins_hiz_out <= next_pins_hiz;
			sdram_cke_hold_low_out <= next_cke_hold;
			boot_start_out <= next_boot_start;
			logic_reset_out <= next_logic_reset;
			wb_dat_out <= next_rdat;
		end
	end

	// Clock buffer gate; the enable is registered from the control bit and pins_hiz_out
	reg buffered_clock_out_en;
	always @(negedge clock_in) begin
		if (rst_in)
			buffered_clock_out_en <= 1'b1;
		else
			buffered_clock_out_en <= ~regulator_control_reg[`PMWC_VR_BUFFERED_CLOCK_OUT_OFF] & ~pins_hiz_out;
	end
	assign buffered_clock_out = clock_in & buffered_clock_out_en;

endmodule

// ==== rtl/pmwc_map.vh ====
`ifndef PMWC_MAP_VH
`define PMWC_MAP_VH
// Register byte addresses
`define PMWC_ADDR_VR 4'h0
`define PMWC_ADDR_PLL 4'h4
`define PMWC_ADDR_MODE 4'h8
`define PMWC_ADDR_CMD 4'hC
// Regulator control fields
`define PMWC_VR_REGULATOR_SWITCH_FIELD_LO 0
`define PMWC_VR_REGULATOR_SWITCH_FIELD_HI 1
`define PMWC_VR_VLEV_LO 4
`define PMWC_VR_VLEV_HI 7
`define PMWC_VR_WAKE_RTC 8
`define PMWC_VR_WAKE_ETH 9
`define PMWC_VR_WAKE_CAN 10
`define PMWC_VR_WAKE_PHY 11
`define PMWC_VR_WAKE_RST 12
`define PMWC_VR_CKE_LOW 13
`define PMWC_VR_BUFFERED_CLOCK_OUT_OFF 14
`define PMWC_VR_RESET 15'h0B01
`define PMWC_REGULATOR_SWITCH_FIELD_OFF 2'h0
`define PMWC_REGULATOR_SWITCH_FIELD_WAKE 2'h1
`define PMWC_SYNC_IDLE 5'h12
`define PMWC_VLEV_STEP_MV 50
// PLL control fields
`define PMWC_PLL_MSEL_LO 1
`define PMWC_PLL_MSEL_HI 6
`define PMWC_PLL_DF 0
`define PMWC_PLL_BYPASS 8
`define PMWC_PLL_RESET 9'h014
`define PMWC_PLL_KEY 16'hA5C3
`define PMWC_MSEL_DEFAULT 6'h0A
// Command register bits
`define PMWC_CMD_DEEP 0
`define PMWC_CMD_ACTIVE 1
`define PMWC_CMD_FULL 2
// Mode codes
`define PMWC_M_FULL 3'h0
`define PMWC_M_ACTIVE 3'h1
`define PMWC_M_DEEP 3'h2
`define PMWC_M_HIB 3'h3
`define PMWC_M_BOOT 3'h4
`define PMWC_BOOT_CYCLES 8'h10
`endif

// ==== tb/pmwc_sva.sv ====
`timescale 1ns/1ps
module pmwc_sva (
	// Clock, reset and bus
	input wire clock_in,
	input wire rst_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_ack_out,
	// Power state
	input wire core_clock_en_out,
	input wire sys_clock_en_out,
	input wire regulator_on_out,
	input wire pll_bypass_out,
	input wire [5:0] pll_msel_out,
	input wire async_access_block_out,
	input wire pins_hiz_out,
	input wire sdram_cke_hold_low_out,
	input wire boot_start_out,
	input wire logic_reset_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	AST_ACK_REQ: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	AST_DEEP_CLK: assert property (
		async_access_block_out |-> !core_clock_en_out && !sys_clock_en_out)
		else $error("clocks run while access blocked");
	AST_HIB_OFF: assert property (
		pins_hiz_out |-> !regulator_on_out && !core_clock_en_out && !sys_clock_en_out)
		else $error("hibernate with supply or clocks on");
	AST_RST_DEF: assert property (
		$fell(rst_in) |-> !pll_bypass_out && pll_msel_out == 6'h0A)
		else $error("wrong pll state after reset");
	AST_BOOT: assert property (boot_start_out |-> $past(logic_reset_out))
		else $error("boot start without prior reset hold");
	AST_CKE: assert property (sdram_cke_hold_low_out |-> logic_reset_out)
		else $error("cke held low outside reset");
	AST_LOST: assert property (!regulator_on_out |-> logic_reset_out)
		else $error("logic not held while unpowered");
endmodule
bind pmwc_ctrl pmwc_sva pmwc_sva_inst (.clock_in, .rst_in, .wb_cyc_in, .wb_stb_in,
	.wb_ack_out, .core_clock_en_out, .sys_clock_en_out, .regulator_on_out,
	.pll_bypass_out, .pll_msel_out, .async_access_block_out, .pins_hiz_out,
	.sdram_cke_hold_low_out, .boot_start_out, .logic_reset_out);

// ==== tb/pmwc_wake_src.sv ====
`timescale 1ns/1ps
module pmwc_wake_src (
	// Clock and bench requests
	input wire clock_in,
	input wire [4:0] req_in,
	// Wake lines
	output reg rtc_irq_out = 1'b0,
	output reg reset_pin_n_out = 1'b1,
	output reg eth_wake_out = 1'b0,
	output reg can_wake_out = 1'b0,
	output reg phy_wake_pin_out = 1'b1
);
	always @(posedge clock_in) begin
		rtc_irq_out <= req_in[0];
		reset_pin_n_out <= !req_in[1];
		eth_wake_out <= req_in[2];
		can_wake_out <= req_in[3];
		// Released pin rests at its pull-up level
		phy_wake_pin_out <= !req_in[4];
	end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	reg clock_in = 1'b0;
	reg rst_in = 1'b1;
	reg cyc = 1'b0;
	reg we = 1'b0;
	reg [3:0] adr = 4'h0;
	reg [31:0] dat = 32'h0;
	reg [4:0] req = 5'h0;
	reg [3:0] sel = 4'hF;
	reg [31:0] v;
	reg [35:0] rows [0:3];
	wire [31:0] rdat;
	wire [3:0] vlev;
	wire [5:0] msel;
	wire ack, rtc, rpn, eth, can, phy, cce, sce, ron, byp, blk, hiz, cke, boot, lrst, bclk, half;
	integer errors = 0;
	integer n_checks = 0;
	integer cc = 0;
	integer nb = 0;
	integer i;
	always #4 clock_in = ~clock_in;
	always @(posedge bclk) nb = nb + 1;
	pmwc_wake_src pmwc_wake_src_inst (.clock_in(clock_in), .req_in(req), .rtc_irq_out(rtc),
		.reset_pin_n_out(rpn), .eth_wake_out(eth), .can_wake_out(can), .phy_wake_pin_out(phy));
	pmwc_ctrl pmwc_ctrl_inst (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .rtc_irq_in(rtc), .reset_pin_n_in(rpn),
		.eth_wake_in(eth), .can_wake_in(can), .phy_wake_pin_in(phy),
		.core_clock_en_out(cce), .sys_clock_en_out(sce), .regulator_on_out(ron),
		.vlevel_out(vlev), .pll_bypass_out(byp), .pll_msel_out(msel), .pll_half_out(half),
		.async_access_block_out(blk), .pins_hiz_out(hiz), .sdram_cke_hold_low_out(cke),
		.boot_start_out(boot), .logic_reset_out(lrst), .buffered_clock_out(bclk));
	task summarize;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	always @(posedge clock_in) begin
		cc <= cc + 1;
		if (cc == 3000) begin
			errors = errors + 1;
			summarize;
		end
	end
	task ck(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clock_in);
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		begin
			@(posedge clock_in);
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			@(posedge clock_in);
			while (ack !== 1'b1) @(posedge clock_in);
			v = rdat;
			cyc <= 1'b0;
		end
	endtask
	task md(input [2:0] m);
		begin
			bus(1'b0, 4'h8, 32'h0);
			ck(v, {29'h0, m});
		end
	endtask
	task bw;
		begin
			for (i = 0; i < 200 && boot !== 1'b1; i = i + 1) @(posedge clock_in);
			ck({31'h0, boot}, 32'h1);
		end
	endtask
	initial begin
		rows[0] = {4'h0, 32'h00000B01};
		rows[1] = {4'h4, 32'h00000014};
		rows[2] = {4'h8, 32'h00000000};
		rows[3] = {4'h2, 32'h00000000};
		tick(3);
		rst_in <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			bus(1'b0, rows[i][35:32], 32'h0);
			ck(v, rows[i][31:0]);
		end
		ck({22'h0, cce, sce, ron, byp, msel}, 32'h38A);
		@(negedge clock_in);
		i = nb;
		tick(10);
		@(negedge clock_in);
		ck(nb - i, 32'hA);
		bus(1'b1, 4'h4, 32'h7E);
		tick(2);
		ck({25'h0, msel, half}, 32'h14);
		bus(1'b1, 4'h4, 32'hA5C3);
		bus(1'b1, 4'h4, 32'h41);
		tick(2);
		ck({25'h0, msel, half}, 32'h41);
		bus(1'b1, 4'hC, 32'h1);
		tick(6);
		ck({29'h0, cce, sce, blk}, 32'h1);
		req <= 5'h1C;
		tick(8);
		md(3'h2);
		req <= 5'h01;
		tick(8);
		md(3'h1);
		ck({30'h0, byp, cce}, 32'h3);
		req <= 5'h0;
		bus(1'b1, 4'hC, 32'h1);
		tick(6);
		req <= 5'h02;
		tick(8);
		req <= 5'h0;
		tick(30);
		md(3'h0);
		bus(1'b1, 4'h0, 32'h6951);
		tick(2);
		ck({28'h0, vlev}, 32'h5);
		@(negedge clock_in);
		i = nb;
		tick(10);
		@(negedge clock_in);
		ck(nb - i, 32'h0);
		bus(1'b1, 4'h0, 32'h6950);
		tick(6);
		md(3'h3);
		ck({29'h0, hiz, ron, cke}, 32'h5);
		req <= 5'h04;
		tick(8);
		ck({31'h0, hiz}, 32'h1);
		req <= 5'h10;
		bw;
		req <= 5'h0;
		tick(4);
		ck({26'h0, msel}, 32'hA);
		bus(1'b0, 4'h0, 32'h0);
		ck(v, 32'h6951);
		bus(1'b1, 4'h0, 32'h0200);
		tick(6);
		req <= 5'h04;
		bw;
		req <= 5'h0;
		rst_in <= 1'b1;
		tick(3);
		rst_in <= 1'b0;
		bus(1'b0, 4'h0, 32'h0);
		ck(v, 32'h00000B01);
		md(3'h0);
		sel <= 4'h2;
		bus(1'b1, 4'h0, 32'h0);
		sel <= 4'hF;
		bus(1'b0, 4'h0, 32'h0);
		ck(v, 32'h00000001);
		summarize;
	end
endmodule
